// ==== hdl/dpt_params.svh ====
// Constants for the DDR2 init and power-down timing block
`ifndef DPT_PARAMS_SVH
`define DPT_PARAMS_SVH
`define DPT_OFF_TIMING 12'h048
`define DPT_OFF_PAD 12'h04c
`define DPT_OFF_CTRL 12'h050
`define DPT_OFF_STAT 12'h054
`define DPT_RST_UNIT 1024
`define DPT_TICK_PERIOD 32
`define DPT_PAD_TIME_RESET 3'h7
`define DPT_PAD_DIS_RESET 1'h0
`define DPT_TIM_RSTN_HI 31
`define DPT_TIM_RSTN_LO 24
`define DPT_TIM_OCD_HI 19
`define DPT_TIM_OCD_LO 16
`define DPT_TIM_FIN_HI 14
`define DPT_TIM_FIN_LO 8
`define DPT_TIM_PD_HI 4
`define DPT_TIM_PD_LO 0
`define DPT_PAD_DIS_BIT 12
`define DPT_PAD_TIME_HI 10
`define DPT_PAD_TIME_LO 8
`define DPT_HYST_HI 7
`define DPT_HYST_LO 0
`define DPT_CTRL_START_BIT 0
`define DPT_CTRL_PDEN_BIT 1
`define DPT_CTRL_PROT_BIT 2
`define DPT_TIM_MASK 32'hff0f7f1f
`endif

// ==== hdl/dpt_pkg.sv ====
// Types for the DDR2 init and power-down timing block
package dpt_pkg;
  typedef enum logic [2:0] {
    DPT_IDLE = 3'b000,
    DPT_RESET_LOW = 3'b001,
    DPT_PRE_OCD = 3'b010,
    DPT_FINAL_WAIT = 3'b011,
    DPT_RUN = 3'b100,
    DPT_POWERDOWN = 3'b101
  } dpt_state_t;
endpackage : dpt_pkg

// ==== hdl/dpt_hysteresis.sv ====
// Go-to-critical hysteresis counter for one queue
`timescale 1ns/1ps
module dpt_hysteresis #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic request,
  input wire logic [W-1:0] limit,
  output logic critical
);
  logic [W-1:0] count_reg;
  wire reached = (count_reg >= limit);
  // Request must be held for limit cycles before going critical
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
      critical <= 1'b0;
    end else if (ce) begin
      if (!request) begin
        count_reg <= '0;
        critical <= 1'b0;
      end else begin
        if (!reached) count_reg <= count_reg + 1'b1;
        critical <= reached;
      end
    end
  end
endmodule : dpt_hysteresis

// ==== hdl/dpt_top.sv ====
// DDR2 init sequencing, power-down timing and queue hysteresis with APB registers
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "dpt_params.svh"
module dpt_top #(
  parameter int HYST_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic DRAM_BUS_IDLE,
  input wire logic INIT_SEQ_DONE,
  input wire logic READ_QUEUE_CRITICAL_REQUEST,
  input wire logic WRITE_QUEUE_CRITICAL_REQUEST,
  output logic DRAM_RESET_N,
  output logic OCD_COMPLETE_CMD,
  output logic SCHEDULER_START,
  output logic POWERDOWN_ACTIVE,
  output logic PAD_POWERDOWN,
  output logic PAD_READY,
  output logic READ_QUEUE_CRITICAL,
  output logic WRITE_QUEUE_CRITICAL
);
  logic [31:0] timing_reg;
  logic pad_dis_reg;
  logic [2:0] pad_time_reg;
  logic [7:0] hyst_reg;
  logic start_reg, pden_reg, prot_reg;
  dpt_pkg::dpt_state_t state_reg, state_next;
  logic [4:0] tick_cnt_reg;
  logic tick_reg;
  logic [17:0] wait_reg;
  logic [4:0] idle_reg;
  logic [2:0] pad_cnt_reg;
  logic pad_target_reg;
  logic rd_crit, wr_crit;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  wire acc = PSEL && PENABLE && CLK_EN;
  wire wr = acc && PWRITE;
  wire sel_tim = hit(PADDR, `DPT_OFF_TIMING);
  wire sel_pad = hit(PADDR, `DPT_OFF_PAD);
  wire sel_ctl = hit(PADDR, `DPT_OFF_CTRL);
  wire sel_sta = hit(PADDR, `DPT_OFF_STAT);
  wire mapped = sel_tim || sel_pad || sel_ctl || sel_sta;
  wire [7:0] f_rstn = timing_reg[`DPT_TIM_RSTN_HI:`DPT_TIM_RSTN_LO];
  wire [3:0] f_ocd = timing_reg[`DPT_TIM_OCD_HI:`DPT_TIM_OCD_LO];
  wire [6:0] f_fin = timing_reg[`DPT_TIM_FIN_HI:`DPT_TIM_FIN_LO];
  wire [4:0] f_pd = timing_reg[`DPT_TIM_PD_HI:`DPT_TIM_PD_LO];
  wire [17:0] rstn_clocks = {f_rstn, 10'h000};
  wire idle_expired = (idle_reg >= f_pd);
  wire leave_pd = !DRAM_BUS_IDLE || !pden_reg;
  wire pad_want = (state_reg == dpt_pkg::DPT_POWERDOWN) && !pad_dis_reg;
  wire pad_settled = (pad_cnt_reg >= pad_time_reg);

  wire [31:0] rd_word =
    sel_tim ? timing_reg :
    sel_pad ? {19'h00000, pad_dis_reg, 1'b0, pad_time_reg, hyst_reg} :
    sel_ctl ? {29'h00000000, prot_reg, pden_reg, start_reg} :
    sel_sta ? {27'h0000000, state_reg, WRITE_QUEUE_CRITICAL, READ_QUEUE_CRITICAL} :
    32'h00000000;

  // APB slave: zero-wait, unmapped access answers with PSLVERR
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CLK_EN) begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      if (PSEL && !PENABLE && !PWRITE) PRDATA <= rd_word;
    end
  end

  wire wr_ok = wr && PREADY;
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      timing_reg <= 32'h00000000;
      pad_dis_reg <= `DPT_PAD_DIS_RESET;
      pad_time_reg <= `DPT_PAD_TIME_RESET;
      hyst_reg <= 8'h00;
      start_reg <= 1'b0;
      pden_reg <= 1'b0;
      prot_reg <= 1'b0;
    end else if (CLK_EN) begin
      if (wr_ok && sel_tim) timing_reg <= PWDATA & `DPT_TIM_MASK;
      if (wr_ok && sel_pad) begin
        hyst_reg <= PWDATA[`DPT_HYST_HI:`DPT_HYST_LO];
        // Protected fields keep their value while protection is on
        if (!prot_reg) begin
          pad_dis_reg <= PWDATA[`DPT_PAD_DIS_BIT];
          pad_time_reg <= PWDATA[`DPT_PAD_TIME_HI:`DPT_PAD_TIME_LO];
        end
      end
      if (wr_ok && sel_ctl) begin
        start_reg <= PWDATA[`DPT_CTRL_START_BIT];
        pden_reg <= PWDATA[`DPT_CTRL_PDEN_BIT];
        prot_reg <= PWDATA[`DPT_CTRL_PROT_BIT];
      end
    end
  end

  // Shared 32-cycle tick drives every x32 count
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      tick_cnt_reg <= 5'h00;
      tick_reg <= 1'b0;
    end else if (CLK_EN) begin
      tick_cnt_reg <= tick_cnt_reg + 5'h01;
      tick_reg <= (tick_cnt_reg == 5'(`DPT_TICK_PERIOD - 1));
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dpt_pkg::DPT_IDLE: if (start_reg) state_next = dpt_pkg::DPT_RESET_LOW;
      dpt_pkg::DPT_RESET_LOW:
        if (wait_reg >= rstn_clocks) state_next = dpt_pkg::DPT_PRE_OCD;
      dpt_pkg::DPT_PRE_OCD:
        if (wait_reg >= {14'h0000, f_ocd}) state_next = dpt_pkg::DPT_FINAL_WAIT;
      dpt_pkg::DPT_FINAL_WAIT:
        if (INIT_SEQ_DONE && wait_reg >= {11'h000, f_fin})
          state_next = dpt_pkg::DPT_RUN;
      dpt_pkg::DPT_RUN:
        if (pden_reg && DRAM_BUS_IDLE && idle_expired)
          state_next = dpt_pkg::DPT_POWERDOWN;
      dpt_pkg::DPT_POWERDOWN:
        if (leave_pd && (pad_settled || !pad_target_reg)) state_next = dpt_pkg::DPT_RUN;
      default: state_next = dpt_pkg::DPT_IDLE;
    endcase
    if (!start_reg) state_next = dpt_pkg::DPT_IDLE;
  end

  // Reset-low counts clocks; later phases count shared ticks
  wire phase_change = (state_next != state_reg);
  wire count_en = (state_reg == dpt_pkg::DPT_RESET_LOW) ? 1'b1 :
    (tick_reg && (state_reg == dpt_pkg::DPT_PRE_OCD ||
    (state_reg == dpt_pkg::DPT_FINAL_WAIT && INIT_SEQ_DONE)));
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_reg <= dpt_pkg::DPT_IDLE;
      wait_reg <= 18'h00000;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      if (phase_change) wait_reg <= 18'h00000;
      else if (count_en && wait_reg != 18'h3ffff) wait_reg <= wait_reg + 18'h00001;
    end
  end

  // Idle timer restarts whenever the bus carries anything but NOP or DESELECT
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      idle_reg <= 5'h00;
    end else if (CLK_EN) begin
      if (state_reg != dpt_pkg::DPT_RUN || !DRAM_BUS_IDLE) idle_reg <= 5'h00;
      else if (tick_reg && !idle_expired) idle_reg <= idle_reg + 5'h01;
    end
  end

  // Pads follow power down unless disabled; each move waits pad time clocks
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pad_target_reg <= 1'b0;
      pad_cnt_reg <= 3'h0;
      PAD_POWERDOWN <= 1'b0;
      PAD_READY <= 1'b1;
    end else if (CLK_EN) begin
      if (pad_want != pad_target_reg) begin
        pad_target_reg <= pad_want;
        pad_cnt_reg <= 3'h0;
        PAD_READY <= 1'b0;
      end else if (!pad_settled) begin
        pad_cnt_reg <= pad_cnt_reg + 3'h1;
      end else begin
        PAD_READY <= 1'b1;
      end
      PAD_POWERDOWN <= pad_target_reg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      DRAM_RESET_N <= 1'b0;
      OCD_COMPLETE_CMD <= 1'b0;
      SCHEDULER_START <= 1'b0;
      POWERDOWN_ACTIVE <= 1'b0;
      READ_QUEUE_CRITICAL <= 1'b0;
      WRITE_QUEUE_CRITICAL <= 1'b0;
    end else if (CLK_EN) begin
      DRAM_RESET_N <= (state_reg != dpt_pkg::DPT_IDLE) &&
        (state_reg != dpt_pkg::DPT_RESET_LOW);
      OCD_COMPLETE_CMD <= (state_reg == dpt_pkg::DPT_PRE_OCD) &&
        (state_next == dpt_pkg::DPT_FINAL_WAIT);
      SCHEDULER_START <= (state_reg == dpt_pkg::DPT_RUN) ||
        (state_reg == dpt_pkg::DPT_POWERDOWN);
      POWERDOWN_ACTIVE <= (state_reg == dpt_pkg::DPT_POWERDOWN);
      READ_QUEUE_CRITICAL <= rd_crit;
      WRITE_QUEUE_CRITICAL <= wr_crit;
    end
  end

  dpt_hysteresis #(.W(HYST_W)) u_rd_hyst (
    .clk(SYS_CLK),
    .rst(RESET),
    .ce(CLK_EN),
    .request(READ_QUEUE_CRITICAL_REQUEST),
    .limit(HYST_W'(hyst_reg)),
    .critical(rd_crit)
  );

  dpt_hysteresis #(.W(HYST_W)) u_wr_hyst (
    .clk(SYS_CLK),
    .rst(RESET),
    .ce(CLK_EN),
    .request(WRITE_QUEUE_CRITICAL_REQUEST),
    .limit(HYST_W'(hyst_reg)),
    .critical(wr_crit)
  );
endmodule : dpt_top

// ==== sim/dpt_dram_model.sv ====
// Behavioural DRAM device on the memory side of the timing block
`timescale 1ns/1ps
module dpt_dram_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic ocd_cmd,
  input wire logic busy,
  output logic bus_idle,
  output logic init_done
);
  // Only NOP or DESELECT on the bus while the bench has no traffic queued
  assign bus_idle = !busy;
  // Init counts as finished from OCD Complete until the next DRAM reset
  always_ff @(posedge clk) begin
    if (rst || !reset_n) begin
      init_done <= 1'b0;
    end else if (ocd_cmd) begin
      init_done <= 1'b1;
    end
  end
endmodule : dpt_dram_model

// ==== sim/dpt_checker.sv ====
// Concurrent checks on the ports of the init and power-down timing block
`timescale 1ns/1ps
module dpt_checker (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic DRAM_BUS_IDLE,
  input wire logic READ_QUEUE_CRITICAL_REQUEST,
  input wire logic DRAM_RESET_N,
  input wire logic OCD_COMPLETE_CMD,
  input wire logic SCHEDULER_START,
  input wire logic POWERDOWN_ACTIVE,
  input wire logic READ_QUEUE_CRITICAL
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire mapped = (PADDR == 12'h048) || (PADDR == 12'h04c) || (PADDR == 12'h050)
    || (PADDR == 12'h054);
  a_ready_next: assert property (CLK_EN && PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_err_decode: assert property (PREADY |-> PSLVERR == !mapped) else $error("bad error flag");
  a_ocd_single: assert property (OCD_COMPLETE_CMD |=> !OCD_COMPLETE_CMD [*8])
    else $error("OCD complete repeated");
  a_ocd_after_reset: assert property (OCD_COMPLETE_CMD |-> DRAM_RESET_N)
    else $error("OCD complete during DRAM reset");
  a_sched_order: assert property ($rose(SCHEDULER_START) |-> DRAM_RESET_N)
    else $error("scheduler started in reset");
  a_pd_cause: assert property ($rose(POWERDOWN_ACTIVE) |-> SCHEDULER_START && $past(DRAM_BUS_IDLE))
    else $error("power down without idle bus");
  // The queue flag is registered twice, so it clears two edges after the request drops
  a_crit_drop: assert property (!READ_QUEUE_CRITICAL_REQUEST |-> ##2 !READ_QUEUE_CRITICAL)
    else $error("critical held without request");
  a_crit_rise: assert property ($rose(READ_QUEUE_CRITICAL) |->
    $past(READ_QUEUE_CRITICAL_REQUEST, 2) && $past(READ_QUEUE_CRITICAL_REQUEST))
    else $error("critical without held request");
  cover property ($rose(POWERDOWN_ACTIVE));
  cover property (PREADY && PSLVERR);
  cover property ($rose(READ_QUEUE_CRITICAL));
endmodule : dpt_checker
bind dpt_top dpt_checker u_chk (.*);

// ==== sim/ddr2_init_powerdown_timing_test.sv ====
// Self-checking bench for the init and power-down timing block
`timescale 1ns/1ps
`include "dpt_params.svh"
module ddr2_init_powerdown_timing_test;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, busy = 1, rq = 0, wq = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, idle, done, rn, ocd, sch, pd, ppd, prdy, rc, wc;
  logic ce = 1;
  int num_errors = 0, samples_checked = 0, cyc = 0, n;
  always #5 clk = ~clk;
  dpt_top uut (.SYS_CLK(clk), .RESET(rst), .CLK_EN(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DRAM_BUS_IDLE(idle), .INIT_SEQ_DONE(done),
    .READ_QUEUE_CRITICAL_REQUEST(rq), .WRITE_QUEUE_CRITICAL_REQUEST(wq), .DRAM_RESET_N(rn),
    .OCD_COMPLETE_CMD(ocd), .SCHEDULER_START(sch), .POWERDOWN_ACTIVE(pd), .PAD_POWERDOWN(ppd),
    .PAD_READY(prdy), .READ_QUEUE_CRITICAL(rc), .WRITE_QUEUE_CRITICAL(wc));
  dpt_dram_model mem (.clk(clk), .rst(rst), .reset_n(rn), .ocd_cmd(ocd), .busy(busy),
    .bus_idle(idle), .init_done(done));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk iff pready === 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  function logic pick(input int k);
    case (k)
      0: return rn;
      1: return ocd;
      2: return sch;
      3: return pd;
      default: return !pd;
    endcase
  endfunction : pick
  // Bounded so a stuck sequencer shows up as a count error, not a hang
  task wait_n(input int k, output int c);
    c = 0;
    while (pick(k) !== 1'b1 && c < 4000) begin
      @(posedge clk);
      c++;
    end
  endtask : wait_n
  task t_regs;
    apb(0, `DPT_OFF_PAD, 0); chk(rd, 32'h00000700);
    apb(1, `DPT_OFF_TIMING, 32'hffffffff); apb(0, `DPT_OFF_TIMING, 0);
    chk(rd, 32'hff0f7f1f);
    apb(0, 12'h05c, 0); chk(er, 1);
    $display("test regs done");
  endtask : t_regs
  task t_protect;
    apb(1, `DPT_OFF_CTRL, 32'h4); apb(1, `DPT_OFF_PAD, 32'h00001355);
    apb(0, `DPT_OFF_PAD, 0); chk(rd, 32'h00000755);
    apb(1, `DPT_OFF_CTRL, 0); apb(1, `DPT_OFF_PAD, 32'h00001355);
    apb(0, `DPT_OFF_PAD, 0); chk(rd, 32'h00001355);
    apb(1, `DPT_OFF_PAD, 32'h00000704);
    $display("test protect done");
  endtask : t_protect
  task t_init;
    apb(1, `DPT_OFF_TIMING, 32'h01020102); apb(1, `DPT_OFF_CTRL, 32'h3);
    wait_n(0, n); chk(n >= 1020 && n <= 1028, 1);
    wait_n(1, n); chk(n >= 28 && n <= 100, 1);
    wait_n(2, n); chk(n <= 100, 1);
    busy <= 1'b0;
    wait_n(3, n); chk(n >= 28 && n <= 110, 1);
    repeat (16) @(posedge clk);
    chk({ppd, prdy}, 2'b11);
    busy <= 1'b1;
    wait_n(4, n); chk(n <= 20, 1);
    $display("test init done");
  endtask : t_init
  task t_pden;
    apb(1, `DPT_OFF_CTRL, 32'h1);
    busy <= 1'b0;
    repeat (200) @(posedge clk);
    chk(pd, 0);
    busy <= 1'b1;
    $display("test pden done");
  endtask : t_pden
  task t_hyst;
    rq <= 1'b1; wq <= 1'b1;
    repeat (4) @(posedge clk);
    chk({rc, wc}, 0);
    repeat (4) @(posedge clk);
    chk({rc, wc}, 2'b11);
    rq <= 1'b0; wq <= 1'b0;
    repeat (3) @(posedge clk);
    chk({rc, wc}, 0);
    // Clock enable low must freeze the hysteresis count
    ce <= 1'b0; rq <= 1'b1;
    repeat (12) @(posedge clk);
    chk(rc, 0);
    ce <= 1'b1;
    repeat (7) @(posedge clk);
    chk(rc, 1);
    rq <= 1'b0;
    $display("test hyst done");
  endtask : t_hyst
  task final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_protect;
    t_init;
    t_pden;
    t_hyst;
    final_report;
  end
endmodule : ddr2_init_powerdown_timing_test
